// ---- core/i2c_bus_condition_client_consts.vh ----
`ifndef I2C_BUS_CONDITION_CLIENT_CONSTS_VH
`define I2C_BUS_CONDITION_CLIENT_CONSTS_VH

// clock period of mclk and hold times, in ns
`define MCLK_NS           20
`define HOLD_LONG_NS      300
`define HOLD_SHORT_NS     100
// hold counts: least times, so round up
`define HOLD_LONG_CYC     ((`HOLD_LONG_NS + `MCLK_NS - 1) / `MCLK_NS)
`define HOLD_SHORT_CYC    ((`HOLD_SHORT_NS + `MCLK_NS - 1) / `MCLK_NS)
`define HOLD_W            5

// bit counter: 8 data bits then the acknowledge bit
`define BIT_W             4
`define BIT_ACK           4'h8
`define BIT_FIRST         4'h0

// fixed upper bits of a 10-bit high address byte
`define TEN_HI_PREFIX     5'h1E
`define TEN_HI_A9         2
`define TEN_HI_A8         1

// client state codes
`define ST_W              3
`define ST_IDLE           3'h0
`define ST_ADDR           3'h1
`define ST_ADDR_LO        3'h2
`define ST_RX             3'h3
`define ST_TX             3'h4
`define ST_IGNORE         3'h5

`endif

// ---- core/i2c_bus_condition_client.v ----
// Operation
// - hold select gives 300 ns data hold
// - idle when no host and both high
// - data falls, clock high: start, active
// - collision when data low but high expected
// - issuing start with data low: collision
// - data rises, clock high: stop
// - stop needs a clock low since start
// - restart valid whenever stop would be
// - restart resets client, expects address
// - valid 10-bit read: stretch clock, prepare
// - prior-match flag set, cleared three ways
// - read-addressed: send bytes until a host NACK, restart or stop
// - address matches only client address value
// - matching write address: receive data bytes
// - 10-bit high byte is 11110 A9 A8 R/W
// - data changes clock low, sampled rising
`include "i2c_bus_condition_client_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_condition_client (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       serial_clock_pin_in,
    output wire       serial_clock_pin_out,
    output wire       serial_clock_pin_oe_n,
    input  wire       serial_data_pin_in,
    output wire       serial_data_pin_out,
    output wire       serial_data_pin_oe_n,
    input  wire       hold_time_select,
    input  wire       ten_bit_mode,
    input  wire [7:0] client_address_reg,
    input  wire       release_clock,
    input  wire       host_start_req,
    input  wire [7:0] tx_data,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        start_det,
    output reg        stop_det,
    output reg        restart_det,
    output reg        bus_collision,
    output reg        bus_active,
    output wire       bus_idle,
    output reg        write_req,
    output reg        read_req,
    output reg        prior_match,
    output wire       clock_held
);

    // counts are worked out as integers, then cut to the counter width
    localparam integer       HOLD_LONG_I  = `HOLD_LONG_CYC;
    localparam integer       HOLD_SHORT_I = `HOLD_SHORT_CYC;
    localparam [`HOLD_W-1:0] HOLD_LONG  = HOLD_LONG_I[`HOLD_W-1:0];
    localparam [`HOLD_W-1:0] HOLD_SHORT = HOLD_SHORT_I[`HOLD_W-1:0];

    reg              scl_m;
    reg              scl_s;
    reg              scl_d;
    reg              sda_m;
    reg              sda_s;
    reg              sda_d;
    reg [`ST_W-1:0]  state;
    reg [`BIT_W-1:0] bitn;
    reg [7:0]        rx_shift;
    reg [7:0]        tx_shift;
    reg              ack_pend;
    reg              stretch_pend;
    reg              hold_scl;
    reg              sda_low;
    reg              sda_next;
    reg [`HOLD_W-1:0] hcnt;
    reg              scl_low_seen;
    reg              gen_start;
    reg              req_d;

    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire sda_fall  = ~sda_s & sda_d & scl_s;
    wire sda_rise  = sda_s & ~sda_d & scl_s;
    wire got_start = sda_fall & (~bus_active | scl_low_seen);
    wire got_stop  = sda_rise & bus_active & scl_low_seen;
    wire [7:0] byte_in = {rx_shift[6:0], sda_s};
    wire       hi_ok  = (byte_in[7:3] == `TEN_HI_PREFIX) &
                        (byte_in[2] == client_address_reg[`TEN_HI_A9]) &
                        (byte_in[1] == client_address_reg[`TEN_HI_A8]);
    wire       in_tx_bits = (state == `ST_TX) & (bitn != `BIT_ACK);
    // collision: line low while we let it float during our own bits
    wire       collide = scl_rise & in_tx_bits & ~sda_low & ~sda_s;

    // open-drain pins: only ever pull low, enable is active low
    assign serial_clock_pin_out  = 1'b0;
    assign serial_data_pin_out   = 1'b0;
    assign serial_clock_pin_oe_n = ~hold_scl;
    assign serial_data_pin_oe_n  = ~(sda_low | gen_start);
    assign clock_held            = hold_scl;
    assign bus_idle = ~bus_active & scl_s & sda_s;

    // two-flop synchronisers; the first stage feeds only the second
    always @(posedge mclk) begin
        if (!rst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= serial_clock_pin_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= serial_data_pin_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // bus condition tracking from synchronised data edges
    always @(posedge mclk) begin
        if (!rst_n) begin
            bus_active   <= 1'b0;
            scl_low_seen <= 1'b0;
            start_det    <= 1'b0;
            stop_det     <= 1'b0;
            restart_det  <= 1'b0;
        end else begin
            start_det   <= got_start & ~bus_active;
            restart_det <= got_start & bus_active;
            stop_det    <= got_stop;
            if (got_start) begin
                bus_active   <= 1'b1;
                scl_low_seen <= 1'b0;
            end else if (got_stop) begin
                bus_active   <= 1'b0;
                scl_low_seen <= 1'b0;
            end else if (bus_active && !scl_s) begin
                // a dip with clock high stays a start only
                scl_low_seen <= 1'b1;
            end
        end
    end

    // data output hold: new level lands a fixed time after clock fall
    always @(posedge mclk) begin
        if (!rst_n) begin
            hcnt    <= {`HOLD_W{1'b0}};
            sda_low <= 1'b0;
        end else if (got_start || got_stop || collide) begin
            hcnt    <= {`HOLD_W{1'b0}};
            sda_low <= 1'b0;
        end else if (scl_fall) begin
            hcnt <= hold_time_select ? HOLD_LONG : HOLD_SHORT;
        end else if (hcnt == {{(`HOLD_W-1){1'b0}}, 1'b1}) begin
            hcnt    <= {`HOLD_W{1'b0}};
            sda_low <= sda_next;
        end else if (hcnt != {`HOLD_W{1'b0}}) begin
            hcnt <= hcnt - {{(`HOLD_W-1){1'b0}}, 1'b1};
        end
    end

    // level to present after the current clock fall
    always @* begin
        sda_next = 1'b0;
        if (bitn == `BIT_ACK)
            sda_next = ack_pend;
        else if (state == `ST_TX)
            sda_next = ~tx_shift[7];
    end

    // start generation and bus collision flag
    always @(posedge mclk) begin
        if (!rst_n) begin
            gen_start     <= 1'b0;
            req_d         <= 1'b0;
            bus_collision <= 1'b0;
        end else begin
            req_d         <= host_start_req;
            bus_collision <= collide;
            if (!host_start_req) begin
                gen_start <= 1'b0;
            end else if (!req_d && !gen_start) begin
                if (!sda_s)
                    bus_collision <= 1'b1;
                else if (bus_idle)
                    gen_start <= 1'b1;
            end
        end
    end

    // client byte engine and address matching
    always @(posedge mclk) begin
        if (!rst_n) begin
            state        <= `ST_IDLE;
            bitn         <= `BIT_FIRST;
            rx_shift     <= 8'h00;
            tx_shift     <= 8'hFF;
            ack_pend     <= 1'b0;
            stretch_pend <= 1'b0;
            hold_scl     <= 1'b0;
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            write_req    <= 1'b0;
            read_req     <= 1'b0;
            prior_match  <= 1'b0;
        end else begin
            rx_valid  <= 1'b0;
            write_req <= 1'b0;
            read_req  <= 1'b0;
            if (got_stop) begin
                state        <= `ST_IDLE;
                prior_match  <= 1'b0;
                ack_pend     <= 1'b0;
                stretch_pend <= 1'b0;
                hold_scl     <= 1'b0;
            end else if (got_start) begin
                // restart acts like start; prior match survives
                state        <= `ST_ADDR;
                bitn         <= `BIT_FIRST;
                ack_pend     <= 1'b0;
                stretch_pend <= 1'b0;
                hold_scl     <= 1'b0;
            end else if (collide) begin
                state <= `ST_IGNORE;
            end else if (scl_rise && state != `ST_IDLE) begin
                if (bitn != `BIT_ACK) begin
                    rx_shift <= byte_in;
                    if (state == `ST_TX)
                        tx_shift <= {tx_shift[6:0], 1'b1};
                    bitn <= bitn + 4'h1;
                    if (bitn == `BIT_ACK - 4'h1) begin
                        case (state)
                        `ST_ADDR: begin
                            if (!ten_bit_mode) begin
                                if (byte_in[7:1] ==
                                    client_address_reg[7:1]) begin
                                    ack_pend <= 1'b1;
                                    if (byte_in[0]) begin
                                        state        <= `ST_TX;
                                        read_req     <= 1'b1;
                                        stretch_pend <= 1'b1;
                                    end else begin
                                        state     <= `ST_RX;
                                        write_req <= 1'b1;
                                    end
                                end else begin
                                    state <= `ST_IGNORE;
                                end
                            end else if (!hi_ok) begin
                                prior_match <= 1'b0;
                                state       <= `ST_IGNORE;
                            end else if (!byte_in[0]) begin
                                prior_match  <= 1'b0;
                                ack_pend     <= 1'b1;
                                stretch_pend <= 1'b1;
                                state        <= `ST_ADDR_LO;
                            end else if (prior_match) begin
                                ack_pend     <= 1'b1;
                                stretch_pend <= 1'b1;
                                read_req     <= 1'b1;
                                state        <= `ST_TX;
                            end else begin
                                state <= `ST_IGNORE;
                            end
                        end
                        `ST_ADDR_LO: begin
                            if (byte_in == client_address_reg) begin
                                prior_match <= 1'b1;
                                ack_pend    <= 1'b1;
                                write_req   <= 1'b1;
                                state       <= `ST_RX;
                            end else begin
                                state <= `ST_IGNORE;
                            end
                        end
                        `ST_RX: begin
                            rx_data  <= byte_in;
                            rx_valid <= 1'b1;
                            ack_pend <= 1'b1;
                        end
                        default: begin
                            ack_pend <= 1'b0;
                        end
                        endcase
                    end
                end else begin
                    // ninth clock: acknowledge bit
                    bitn     <= `BIT_FIRST;
                    ack_pend <= 1'b0;
                    if (state == `ST_TX) begin
                        if (!sda_s)
                            tx_shift <= tx_data;
                        else
                            state <= `ST_IGNORE;
                    end
                end
            end else if (scl_fall && bitn == `BIT_FIRST && stretch_pend) begin
                // hold clock low after the ack so software can prepare
                hold_scl     <= 1'b1;
                stretch_pend <= 1'b0;
            end else if (hold_scl && release_clock) begin
                hold_scl <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- bench/i2c_bus_condition_client_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_condition_client_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_clock_pin_in,
    input wire logic serial_data_pin_in,
    input wire logic serial_clock_pin_oe_n,
    input wire logic start_det,
    input wire logic stop_det,
    input wire logic restart_det,
    input wire logic bus_collision,
    input wire logic bus_active,
    input wire logic bus_idle,
    input wire logic read_req,
    input wire logic prior_match,
    input wire logic clock_held
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic low_seen;
    // clock low since the last start; cleared by a start so a dip stays one
    always @(posedge mclk) begin
        if (!rst_n)
            low_seen <= 1'b0;
        else if (start_det | restart_det)
            low_seen <= !serial_clock_pin_in;
        else
            low_seen <= low_seen | !serial_clock_pin_in;
    end
    // pin levels three edges back, where the synchroniser found the edge
    sequence s_both_high;
        $past(serial_data_pin_in, 3) && $past(serial_clock_pin_in, 3);
    endsequence
    sequence s_data_fell;
        !$past(serial_data_pin_in, 3) && $past(serial_clock_pin_in, 3);
    endsequence
    a_start_edge: assert property (start_det |-> s_data_fell)
        else $error("start without data low under clock high");
    a_start_active: assert property (start_det |-> ##[0:1] bus_active)
        else $error("start did not make the bus active");
    a_restart_valid: assert property (restart_det |-> s_data_fell ##0 low_seen)
        else $error("restart without a clock low or data fall");
    a_stop_valid: assert property (stop_det |-> s_both_high ##0 low_seen)
        else $error("stop without a clock low or data rise");
    a_idle_pins: assert property (bus_idle |-> !bus_active
        && $past(serial_data_pin_in, 2) && $past(serial_clock_pin_in, 2))
        else $error("idle while active or a pin low");
    a_collide_low: assert property (bus_collision |-> !$past(serial_data_pin_in, 3))
        else $error("collision while the data pin was high");
    a_held_pulls: assert property (clock_held |-> !serial_clock_pin_oe_n && !serial_clock_pin_in)
        else $error("clock held but not pulled low");
    a_read_stretch: assert property (read_req |-> ##[1:80] clock_held)
        else $error("read request without a clock stretch");
    a_prior_stop: assert property (stop_det |=> !prior_match)
        else $error("prior match kept after a stop");
endmodule
bind i2c_bus_condition_client i2c_bus_condition_client_chk chk_u (.*);
`default_nettype wire

// ---- bench/i2c_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    input  wire logic mclk,
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_drv,
    output var  logic sda_drv
);
    int hold_cyc = 0;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // wait for the released clock to go high, riding out a client stretch, bounded
    task automatic rise();
        for (int k = 0; k < 400 && !scl; k++)
            wt(1);
        wt(4);
    endtask
    // low phase outlasts the long hold, so the client is done before we rise
    task automatic put_bit(input logic b, output logic r);
        wt(10);
        sda_drv = b; // change only with clock low
        wt(10);
        scl_drv = 1'b1;
        rise();
        r = sda;
        wt(4);
        scl_drv = 1'b0;
    endtask
    // start from idle, or restart after a clock low
    task automatic open_frame();
        sda_drv = 1'b1;
        wt(10);
        scl_drv = 1'b1;
        rise();
        sda_drv = 1'b0;
        wt(4);
        scl_drv = 1'b0;
    endtask
    task automatic close_frame();
        wt(10);
        sda_drv = 1'b0;
        wt(10);
        scl_drv = 1'b1;
        rise();
        sda_drv = 1'b1;
        wt(10);
    endtask
    // one byte msb first, then the acknowledge bit driven as ha
    task automatic xfer(input logic [7:0] d, input logic ha,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], q[i]);
        wt(1); // let the clock fall settle before data moves
        sda_drv = 1'b1;
        hold_cyc = 0;
        do begin
            wt(1);
            hold_cyc++;
        end while (sda && hold_cyc < 40);
        put_bit(ha, ack);
    endtask
    task automatic set_sda(input logic v);
        sda_drv = v;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_i2c_bus_condition_client.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_bus_condition_client;
    logic       mclk = 0, rst_n = 0, hold_sel = 0, ten_bit = 0;
    logic       rel_clk = 0, start_req = 0, ack;
    logic [7:0] addr = 8'h5A, txd = 8'h00, q;
    wire logic  scl_w, sda_w, scl_oe_n, sda_oe_n, h_scl, h_sda;
    wire logic  scl_out, sda_out, rx_valid, start_det, stop_det, restart_det;
    wire logic  collision, active, idle, write_req, read_req, prior, held;
    wire logic [7:0] rx_data;
    int         failures = 0, checks_done = 0, n[7];
    always #10 mclk = ~mclk;
    // open-drain wires with pull-ups
    assign scl_w = h_scl & scl_oe_n;
    assign sda_w = h_sda & sda_oe_n;
    // software frees any stretch a cycle later
    always @(negedge mclk) rel_clk <= held & !rel_clk;
    // tally pulses: start, stop, restart, collision, write, read, data
    always @(posedge mclk) begin
        n[0] += start_det;
        n[1] += stop_det;
        n[2] += restart_det;
        n[3] += collision;
        n[4] += write_req;
        n[5] += read_req;
        n[6] += rx_valid;
    end
    i2c_host_model hm (.mclk(mclk), .scl(scl_w), .sda(sda_w),
        .scl_drv(h_scl), .sda_drv(h_sda));
    i2c_bus_condition_client dut_u (
        .mclk(mclk), .rst_n(rst_n), .serial_clock_pin_in(scl_w),
        .serial_clock_pin_out(scl_out), .serial_clock_pin_oe_n(scl_oe_n),
        .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_out),
        .serial_data_pin_oe_n(sda_oe_n), .hold_time_select(hold_sel),
        .ten_bit_mode(ten_bit), .client_address_reg(addr),
        .release_clock(rel_clk), .host_start_req(start_req), .tx_data(txd),
        .rx_data(rx_data), .rx_valid(rx_valid), .start_det(start_det),
        .stop_det(stop_det), .restart_det(restart_det),
        .bus_collision(collision), .bus_active(active), .bus_idle(idle),
        .write_req(write_req), .read_req(read_req), .prior_match(prior),
        .clock_held(held));
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // 7-bit write of one byte under the chosen hold
    task t_write(input logic hs);
        hold_sel = hs;
        n = '{default: 0};
        hm.open_frame();
        hm.xfer(8'h5A, 1'b1, q, ack);
        chk("addr ack", ack, 0);
        chk("write req", n[4], 1);
        chk("long hold", hm.hold_cyc >= 15, hs);
        chk("hold floor", hm.hold_cyc >= 5, 1);
        hm.xfer(8'hC3, 1'b1, q, ack);
        chk("rx data", rx_data, 8'hC3);
        chk("rx valid", n[6], 1);
        hm.close_frame();
        chk("starts", n[0], 1);
        chk("stops", n[1], 1);
        chk("idle", idle, 1);
        chk("pin outs", {scl_out, sda_out}, 0);
        $display("write test done");
    endtask
    // foreign address: no acknowledge and no request
    task t_nomatch();
        n = '{default: 0};
        hm.open_frame();
        hm.xfer(8'h5C, 1'b1, q, ack);
        chk("nomatch ack", ack, 1);
        chk("nomatch req", n[4], 0);
        hm.close_frame();
        $display("nomatch test done");
    endtask
    // write address, restart, read two bytes, last one refused
    task t_read();
        n = '{default: 0};
        txd = 8'hA5;
        hm.open_frame();
        hm.xfer(8'h5A, 1'b1, q, ack);
        hm.open_frame();
        hm.xfer(8'h5B, 1'b1, q, ack);
        txd = 8'h3C;
        chk("restart", n[2], 1);
        chk("readdr ack", ack, 0);
        chk("read req", n[5], 1);
        hm.xfer(8'hFF, 1'b0, q, ack);
        chk("rd byte 1", q, 8'hA5);
        hm.xfer(8'hFF, 1'b1, q, ack);
        chk("rd byte 2", q, 8'h3C);
        hm.close_frame();
        chk("rd stop", n[1], 1);
        $display("read test done");
    endtask
    // 10-bit write match, then restart and high byte with read set
    task t_ten();
        ten_bit = 1;
        addr = 8'h06;
        n = '{default: 0};
        hm.open_frame();
        hm.xfer(8'hF6, 1'b1, q, ack);
        chk("high ack", ack, 0);
        hm.xfer(8'h06, 1'b1, q, ack);
        chk("prior set", prior, 1);
        hm.open_frame();
        hm.xfer(8'hF7, 1'b1, q, ack);
        chk("ten read", n[5], 1);
        chk("prior kept", prior, 1);
        hm.xfer(8'hFF, 1'b1, q, ack);
        hm.close_frame();
        chk("prior clr", prior, 0);
        ten_bit = 0;
        addr = 8'h5A;
        $display("ten-bit test done");
    endtask
    // data dip under a high clock, with a start request onto the low line
    task t_dip();
        n = '{default: 0};
        hm.set_sda(1'b0);
        hm.wt(8);
        start_req = 1;
        hm.wt(8);
        chk("collision", n[3], 1);
        start_req = 0;
        hm.set_sda(1'b1);
        hm.wt(10);
        chk("dip start", n[0], 1);
        chk("dip no stop", n[1], 0);
        chk("dip active", active, 1);
        hm.open_frame();
        hm.close_frame();
        chk("late stop", n[1], 1);
        // start request onto an idle bus: own pull, no collision
        start_req = 1;
        hm.wt(8);
        chk("own start", n[0], 2);
        chk("own pull", sda_oe_n, 0);
        chk("no collide", n[3], 1);
        start_req = 0;
        hm.open_frame();
        hm.close_frame();
        chk("own stop", n[1], 2);
        $display("dip test done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk) rst_n = 1;
        hm.wt(4);
        t_write(1'b1);
        t_write(1'b0);
        t_nomatch();
        t_read();
        t_ten();
        t_dip();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        $display("timeout");
        wrap_up();
    end
endmodule
`default_nettype wire
